// File: hw/scd_core.sv
/*
 * system-control core: fetches 16-bit codes, executes the system-control
 * group and sized loads/stores over one shared bus, models load-use stalls.
 * assumes bus_ack answers bus_req and rdata arrives right-aligned with it.
 */
`default_nettype none
// Function
// [RL1] move general register into control register
// [RL2] copy control register into general register
// [RL3] move between general and system registers
// [RL4] exception return restores saved pc and status
// [RL5] low-power instruction enters power-down state
// [RL6] software trap starts trap exception handling
// [RL7] byte, word, longword sizes with matching access
// [RL8] 4-bit register fields select register directly
// [RL9] displacement scaled by one, two or four
// [RL10] listed cycles minimum; bus contention adds cycles
// [RL11] stall when next instruction reads loading register
// [RL12] flag clear/set, accumulator clear, no-op
module scd_core #(
    parameter logic [31:0] RESET_PC = 32'h0000_0000
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // shared instruction and data bus
    output logic bus_req_q,
    output logic bus_fetch_q,
    output logic bus_we_q,
    output scd_pkg::scd_size_t bus_size_q,
    output logic [31:0] bus_addr_q,
    output logic [31:0] bus_wdata_q,
    input wire logic bus_ack,
    input wire logic [31:0] bus_rdata,
    // wake from power-down
    input wire logic wake,
    // status
    output logic [31:0] status_q,
    output logic [31:0] pc_q,
    output logic power_down_q,
    output logic trap_q,
    output logic stall_ld_q,
    output logic contend_q
);
    import scd_pkg::*;

    scd_state_t q;
    scd_state_t d;
    logic hit;
    logic fetch_done;
    scd_core_if u_if();

    scd_decode u_dec (
        .d(u_if.dec)
    );

    scd_regfile #(
        .DEPTH(RF_DEPTH)
    ) u_rf (
        .clk_sys(clk_sys),
        .rst(rst),
        .r(u_if.rf)
    );

    // sign-extend a narrow load into a full word
    function automatic logic [31:0] ext(input logic [31:0] v, input scd_size_t s);
        case (s)
            SZ_B: ext = {{24{v[7]}}, v[7:0]};
            SZ_W: ext = {{16{v[15]}}, v[15:0]};
            default: ext = v;
        endcase
    endfunction

    // decoder sees the fetched code in the cycle it arrives
    assign fetch_done = (q.st == S_FETCH) && bus_ack;
    assign u_if.insn = fetch_done ? bus_rdata[15:0] : q.insn;

    // next state
    always_comb begin
        d = q;
        d.trap = 1'b0;
        d.stall = 1'b0;
        d.contend = 1'b0;
        u_if.rf_we = 1'b0;
        u_if.rf_wa = q.ld_dst;
        u_if.rf_wd = q.ld_data;
        hit = 1'b0;
        case (q.st)
            S_FETCH: begin
                // a finished load writes back in the first fetch cycle
                if (q.ld_pend) begin
                    u_if.rf_we = 1'b1;
                    d.ld_pend = 1'b0;
                end
                if (bus_ack) begin
                    d.insn = bus_rdata[15:0];
                    d.bus_req = 1'b0;
                    d.pc = q.pc + INSN_STEP;
                    // read ports race the writeback: hold one cycle
                    hit = q.ld_pend && (((u_if.op == OP_LDC || u_if.op == OP_LDS
                        || u_if.op == OP_LOAD || u_if.op == OP_STORE)
                        && u_if.ra == q.ld_dst)
                        || (u_if.op == OP_STORE && u_if.rb == q.ld_dst));
                    d.stall = hit; // see [RL11]
                    d.st = hit ? S_STALL : S_EXEC; // see [RL11]
                end
            end
            S_STALL: begin
                d.st = S_EXEC;
            end
            S_EXEC: begin
                d.st = S_FETCH;
                case (u_if.op)
                    OP_FLAG_CLEAR_INSN: d.sr[T_BIT] = 1'b0; // see [RL12]
                    OP_FLAG_SET_INSN: d.sr[T_BIT] = 1'b1; // see [RL12]
                    OP_ACCUMULATOR_CLEAR_INSN: begin
                        d.mach = WORD_ZERO; // see [RL12]
                        d.macl = WORD_ZERO;
                    end
                    OP_SLEEP: begin
                        d.st = S_SLEEP;
                        d.pdown = 1'b1; // see [RL5]
                    end
                    OP_RTE: begin
                        d.pc = q.spc; // see [RL4]
                        d.sr = q.ssr;
                    end
                    OP_TRAP: begin
                        // save context, then read the vector word
                        d.ssr = q.sr; // see [RL6]
                        d.spc = q.pc;
                        d.trap = 1'b1;
                        d.st = S_VEC;
                        d.bus_req = 1'b1;
                        d.bus_fetch = 1'b0;
                        d.bus_we = 1'b0;
                        d.bus_size = SZ_L;
                        d.bus_addr = q.vbr + {22'h0, u_if.imm, 2'b00};
                    end
                    OP_LDC: begin
                        case (u_if.sel)
                            SEL_0: d.sr = u_if.rf_da & SR_MASK; // see [RL1]
                            SEL_1: d.gbr = u_if.rf_da;
                            SEL_2: d.vbr = u_if.rf_da;
                            default: d.sr = q.sr;
                        endcase
                    end
                    OP_LDS: begin
                        case (u_if.sel)
                            SEL_0: d.mach = u_if.rf_da; // see [RL3]
                            SEL_1: d.macl = u_if.rf_da;
                            SEL_2: d.pr = u_if.rf_da;
                            default: d.pr = q.pr;
                        endcase
                    end
                    OP_STC, OP_STS: begin
                        // see [RL2] see [RL3]
                        u_if.rf_we = 1'b1;
                        u_if.rf_wa = u_if.rw;
                        case ({u_if.op == OP_STS, u_if.sel})
                            {1'b0, SEL_0}: u_if.rf_wd = q.sr;
                            {1'b0, SEL_1}: u_if.rf_wd = q.gbr;
                            {1'b0, SEL_2}: u_if.rf_wd = q.vbr;
                            {1'b1, SEL_0}: u_if.rf_wd = q.mach;
                            {1'b1, SEL_1}: u_if.rf_wd = q.macl;
                            {1'b1, SEL_2}: u_if.rf_wd = q.pr;
                            default: u_if.rf_wd = WORD_ZERO;
                        endcase
                    end
                    OP_LOAD, OP_STORE: begin
                        d.st = S_MEM;
                        d.bus_req = 1'b1;
                        d.bus_fetch = 1'b0;
                        d.bus_we = (u_if.op == OP_STORE);
                        d.bus_size = u_if.size; // see [RL7]
                        d.bus_addr = u_if.rf_da + u_if.disp; // see [RL9]
                        d.bus_wdata = u_if.rf_db;
                        d.is_load = (u_if.op == OP_LOAD);
                        d.ld_dst = u_if.rw;
                    end
                    default: d.st = S_FETCH; // no-op leaves all state, see [RL12]
                endcase
            end
            S_MEM: begin
                // the next fetch waits while data owns the bus
                if (bus_ack) begin
                    d.bus_req = 1'b0;
                    d.bus_we = 1'b0;
                    d.st = S_FETCH;
                    if (q.is_load) begin
                        d.ld_data = ext(bus_rdata, q.bus_size); // see [RL7]
                        d.ld_pend = 1'b1;
                    end
                end else begin
                    d.contend = 1'b1; // see [RL10]
                end
            end
            S_VEC: begin
                if (bus_ack) begin
                    d.bus_req = 1'b0;
                    d.pc = bus_rdata;
                    d.st = S_FETCH;
                end
            end
            S_SLEEP: begin
                if (wake) begin
                    d.pdown = 1'b0;
                    d.st = S_FETCH;
                end
            end
            default: d.st = S_FETCH;
        endcase
        // entering fetch issues the code request at the new pc
        if (d.st == S_FETCH && q.st != S_FETCH) begin
            d.bus_req = 1'b1;
            d.bus_fetch = 1'b1;
            d.bus_we = 1'b0;
            d.bus_size = SZ_W;
            d.bus_addr = d.pc;
        end
    end

    // state register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.st <= S_FETCH;
            q.pc <= RESET_PC;
            q.sr <= SR_RESET;
            q.bus_req <= 1'b1;
            q.bus_fetch <= 1'b1;
            q.bus_size <= SZ_W;
            q.bus_addr <= RESET_PC;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign bus_req_q = q.bus_req;
    assign bus_fetch_q = q.bus_fetch;
    assign bus_we_q = q.bus_we;
    assign bus_size_q = q.bus_size;
    assign bus_addr_q = q.bus_addr;
    assign bus_wdata_q = q.bus_wdata;
    assign status_q = q.sr;
    assign pc_q = q.pc;
    assign power_down_q = q.pdown;
    assign trap_q = q.trap;
    assign stall_ld_q = q.stall;
    assign contend_q = q.contend;

    // checks on decoded execution
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic ex;
    assign ex = (q.st == S_EXEC);

    sequence s_trap_vec;
        trap_q && q.st == S_VEC && bus_req_q && !bus_fetch_q && bus_size_q == SZ_L;
    endsequence
    sequence s_ld_stall;
        stall_ld_q && q.st == S_STALL ##1 q.st == S_EXEC;
    endsequence

    a_ldc_status: assert property (ex && u_if.op == OP_LDC && u_if.sel == SEL_0 // see [RL1]
        |=> status_q == ($past(u_if.rf_da) & SR_MASK)) else $error("ldc to status wrong");
    a_stc_write: assert property (ex && u_if.op == OP_STC // see [RL2]
        |-> u_if.rf_we && u_if.rf_wa == q.insn[11:8]) else $error("stc write wrong");
    a_lds_high: assert property (ex && u_if.op == OP_LDS && u_if.sel == SEL_0 // see [RL3]
        |=> q.mach == $past(u_if.rf_da)) else $error("lds to acc high wrong");
    a_rte_restore: assert property (ex && u_if.op == OP_RTE // see [RL4]
        |=> pc_q == $past(q.spc) && status_q == $past(q.ssr)) else $error("rte restore wrong");
    a_sleep_entry: assert property (ex && u_if.op == OP_SLEEP // see [RL5]
        |=> power_down_q && !bus_req_q) else $error("sleep not entered");
    a_trap_entry: assert property (ex && u_if.op == OP_TRAP |=> s_trap_vec) // see [RL6]
        else $error("trap not started");
    a_load_size: assert property (ex && u_if.op == OP_LOAD // see [RL7]
        |=> bus_req_q && bus_size_q == $past(u_if.size) && !bus_we_q)
        else $error("load size wrong");
    a_disp_long: assert property (ex && u_if.op == OP_LOAD && q.insn[15:12] == G_LDL // see [RL9]
        |=> bus_addr_q == $past(u_if.rf_da) + {26'h0, $past(q.insn[3:0]), 2'b00})
        else $error("longword displacement not scaled");
    a_bus_wait: assert property (q.st == S_MEM && !bus_ack // see [RL10]
        |=> q.st == S_MEM && contend_q && bus_req_q) else $error("wait not held");
    a_ld_use_stall: assert property (fetch_done && hit |=> s_ld_stall) // see [RL11]
        else $error("load-use stall missing");
    a_flag_clear: assert property (ex && u_if.op == OP_FLAG_CLEAR_INSN // see [RL12]
        |=> !status_q[T_BIT] && q.st == S_FETCH) else $error("flag not cleared");
    a_mac_clear: assert property (ex && u_if.op == OP_ACCUMULATOR_CLEAR_INSN // see [RL12]
        |=> q.mach == WORD_ZERO && q.macl == WORD_ZERO) else $error("acc not cleared");
    a_flag_set: assert property (ex && u_if.op == OP_FLAG_SET_INSN // see [RL12]
        |=> status_q[T_BIT] && q.st == S_FETCH) else $error("flag not set");
    a_sts_write: assert property (ex && u_if.op == OP_STS // see [RL3]
        |-> u_if.rf_we && u_if.rf_wa == q.insn[11:8]) else $error("sts write wrong");

    // a load-use hold lasts exactly one cycle, then the held code executes
    a_stall_once: assert property (q.st == S_STALL // see [RL11]
        |=> q.st == S_EXEC && !stall_ld_q) else $error("stall longer than one cycle");
endmodule
`default_nettype wire

// File: hw/scd_pkg.sv
/*
 * shared constants, instruction patterns, enums and the core state record
 * for the system-control instruction decoder and executor.
 * assumes 16-bit instructions and a 32-bit shared instruction/data bus.
 */
`default_nettype none
package scd_pkg;
    localparam int XLEN = 32;
    localparam int RF_DEPTH = 16;
    localparam int RA_W = 4;
    // fixed system-control opcodes
    localparam logic [15:0] I_FLAG_CLEAR_INSN = 16'h0008;
    localparam logic [15:0] I_FLAG_SET_INSN = 16'h0018;
    localparam logic [15:0] I_ACCUMULATOR_CLEAR_INSN = 16'h0028;
    localparam logic [15:0] I_NOP = 16'h0009;
    localparam logic [15:0] I_SLEEP = 16'h001B;
    localparam logic [15:0] I_RTE = 16'h002B;
    // group patterns
    localparam logic [7:0] G_TRAP = 8'hC3;
    localparam logic [3:0] G_CTL_LD = 4'h4;
    localparam logic [3:0] G_CTL_ST = 4'h0;
    localparam logic [3:0] G_LD = 4'h6;
    localparam logic [3:0] G_ST = 4'h2;
    localparam logic [3:0] G_LDL = 4'h5;
    localparam logic [3:0] G_STL = 4'h1;
    localparam logic [6:0] G_LDBW = 7'h42;
    localparam logic [6:0] G_STBW = 7'h40;
    localparam logic [3:0] F_LDC = 4'hE;
    localparam logic [3:0] F_STC = 4'h2;
    localparam logic [3:0] F_SYS = 4'hA;
    localparam logic [1:0] F_BAD_SZ = 2'h3;
    localparam logic [3:0] R_ZERO = 4'h0;
    // status register layout
    localparam int T_BIT = 0;
    localparam logic [31:0] SR_MASK = 32'h0000_03F3;
    localparam logic [31:0] SR_RESET = 32'h0000_00F0;
    localparam logic [31:0] INSN_STEP = 32'h0000_0002;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    typedef enum logic [1:0] {SZ_B = 2'h0, SZ_W = 2'h1, SZ_L = 2'h2} scd_size_t;
    // selector: status/accumulator-high, base/accumulator-low, vector/return
    localparam logic [1:0] SEL_0 = 2'h0;
    localparam logic [1:0] SEL_1 = 2'h1;
    localparam logic [1:0] SEL_2 = 2'h2;
    typedef enum logic [3:0] {
        OP_NOP, OP_FLAG_CLEAR_INSN, OP_FLAG_SET_INSN, OP_ACCUMULATOR_CLEAR_INSN, OP_SLEEP, OP_RTE, OP_TRAP,
        OP_LDC, OP_STC, OP_LDS, OP_STS, OP_LOAD, OP_STORE
    } scd_op_t;
    typedef enum logic [5:0] {
        S_FETCH = 6'h01, S_STALL = 6'h02, S_EXEC = 6'h04,
        S_MEM = 6'h08, S_VEC = 6'h10, S_SLEEP = 6'h20
    } scd_st_t;
    typedef struct packed {
        scd_st_t st;
        logic [31:0] pc;
        logic [31:0] sr;
        logic [31:0] gbr;
        logic [31:0] vbr;
        logic [31:0] mach;
        logic [31:0] macl;
        logic [31:0] pr;
        logic [31:0] spc;
        logic [31:0] ssr;
        logic [15:0] insn;
        logic is_load;
        logic [3:0] ld_dst;
        logic [31:0] ld_data;
        logic ld_pend;
        logic bus_req;
        logic bus_fetch;
        logic bus_we;
        scd_size_t bus_size;
        logic [31:0] bus_addr;
        logic [31:0] bus_wdata;
        logic pdown;
        logic trap;
        logic stall;
        logic contend;
    } scd_state_t;
endpackage
`default_nettype wire

// File: hw/scd_core_if.sv
/*
 * carrier between the core, its decoder and its register file.
 * assumes the decoder is purely combinational.
 */
`default_nettype none
interface scd_core_if;
    import scd_pkg::*;
    logic [15:0] insn;
    scd_op_t op;
    logic [1:0] sel;
    logic [3:0] ra;
    logic [3:0] rb;
    logic [3:0] rw;
    scd_size_t size;
    logic [31:0] disp;
    logic [7:0] imm;
    logic rf_we;
    logic [3:0] rf_wa;
    logic [31:0] rf_wd;
    logic [31:0] rf_da;
    logic [31:0] rf_db;
    modport dec (input insn, output op, sel, ra, rb, rw, size, disp, imm);
    modport rf (input ra, rb, rf_we, rf_wa, rf_wd, output rf_da, rf_db);
    modport core (output insn, rf_we, rf_wa, rf_wd,
        input op, sel, ra, rb, rw, size, disp, imm, rf_da, rf_db);
endinterface
`default_nettype wire

// File: hw/scd_regfile.sv
/*
 * sixteen general registers, two read ports with registered data, one write.
 * assumes reads return the value held before a same-cycle write.
 */
`default_nettype none
module scd_regfile #(
    parameter int DEPTH = scd_pkg::RF_DEPTH
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register access
    scd_core_if.rf r
);
    import scd_pkg::*;
    logic [31:0] mem [DEPTH];
    logic [31:0] da_q;
    logic [31:0] db_q;

    // write port and registered read ports
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            da_q <= WORD_ZERO;
            db_q <= WORD_ZERO;
        end else begin
            da_q <= mem[r.ra];
            db_q <= mem[r.rb];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (r.rf_we) begin
            mem[r.rf_wa] <= r.rf_wd;
        end
    end

    assign r.rf_da = da_q;
    assign r.rf_db = db_q;
endmodule
`default_nettype wire

// File: hw/scd_decode.sv
/*
 * combinational decode of system-control and sized transfer opcodes.
 * assumes unrecognised codes are handled by other groups; here they act as no-op.
 */
`default_nettype none
module scd_decode (
    // decode fields
    scd_core_if.dec d
);
    import scd_pkg::*;

    // scale a 4-bit displacement by the operand size
    function automatic logic [31:0] scale(input logic [3:0] v, input scd_size_t s);
        case (s)
            SZ_W: scale = {27'h0, v, 1'b0};
            SZ_L: scale = {26'h0, v, 2'b00};
            default: scale = {28'h0, v};
        endcase
    endfunction

    // field extraction: source in 7:4, destination in 11:8, direct numbering
    always_comb begin
        logic [15:0] i;
        i = d.insn;
        d.op = OP_NOP;
        d.sel = i[5:4];
        d.ra = i[7:4]; // see [RL8]
        d.rb = i[7:4];
        d.rw = i[11:8]; // see [RL8]
        d.size = SZ_L;
        d.disp = WORD_ZERO;
        d.imm = i[7:0];
        case (i)
            I_FLAG_CLEAR_INSN: d.op = OP_FLAG_CLEAR_INSN;
            I_FLAG_SET_INSN: d.op = OP_FLAG_SET_INSN;
            I_ACCUMULATOR_CLEAR_INSN: d.op = OP_ACCUMULATOR_CLEAR_INSN;
            I_SLEEP: d.op = OP_SLEEP;
            I_RTE: d.op = OP_RTE;
            default: begin
                if (i[15:8] == G_TRAP) begin
                    d.op = OP_TRAP;
                end else if (i[15:12] == G_CTL_LD && i[7:6] == 2'h0 && i[3:0] == F_LDC) begin
                    d.op = OP_LDC;
                    d.ra = i[11:8];
                end else if (i[15:12] == G_CTL_LD && i[7:6] == 2'h0 && i[3:0] == F_SYS) begin
                    d.op = OP_LDS;
                    d.ra = i[11:8];
                end else if (i[15:12] == G_CTL_ST && i[7:6] == 2'h0 && i[3:0] == F_STC) begin
                    d.op = OP_STC;
                end else if (i[15:12] == G_CTL_ST && i[7:6] == 2'h0 && i[3:0] == F_SYS) begin
                    d.op = OP_STS;
                end else if (i[15:12] == G_LD && i[3:2] == 2'h0 && i[1:0] != F_BAD_SZ) begin
                    d.op = OP_LOAD;
                    d.size = scd_size_t'(i[1:0]); // see [RL7]
                end else if (i[15:12] == G_ST && i[3:2] == 2'h0 && i[1:0] != F_BAD_SZ) begin
                    d.op = OP_STORE;
                    d.ra = i[11:8];
                    d.size = scd_size_t'(i[1:0]); // see [RL7]
                end else if (i[15:12] == G_LDL) begin
                    d.op = OP_LOAD;
                    d.disp = scale(i[3:0], SZ_L); // see [RL9]
                end else if (i[15:12] == G_STL) begin
                    d.op = OP_STORE;
                    d.ra = i[11:8];
                    d.disp = scale(i[3:0], SZ_L); // see [RL9]
                end else if (i[15:9] == G_LDBW || i[15:9] == G_STBW) begin
                    d.op = (i[15:9] == G_LDBW) ? OP_LOAD : OP_STORE;
                    d.rw = R_ZERO;
                    d.rb = R_ZERO;
                    d.size = scd_size_t'({1'b0, i[8]});
                    d.disp = scale(i[3:0], scd_size_t'({1'b0, i[8]})); // see [RL9]
                end
            end
        endcase
    end
endmodule
`default_nettype wire

// File: testbench/scd_mem_model.sv
/*
 * shared instruction/data memory answering the core's bus, big-endian bytes.
 * assumes one outstanding request; wait_n sets the wait states before ack.
 */
`default_nettype none
module scd_mem_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // bus from the core
    input wire logic bus_req,
    input wire logic bus_we,
    input wire scd_pkg::scd_size_t bus_size,
    input wire logic [31:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    output logic bus_ack,
    output logic [31:0] bus_rdata,
    // wait states per access
    input wire logic [3:0] wait_n
);
    import scd_pkg::*;
    logic [7:0] m [0:511];
    logic [3:0] cnt_q;
    logic [31:0] last_q;
    logic [8:0] a;
    int nb;
    assign a = bus_addr[8:0];
    assign nb = 1 << bus_size;
    // ack after the chosen number of wait cycles, one cycle long
    assign bus_ack = bus_req && (cnt_q == wait_n);
    // read data only with ack; otherwise a pattern that changes every cycle
    always_comb begin
        bus_rdata = ~last_q;
        if (bus_ack) begin
            bus_rdata = 32'h0000_0000;
            for (int i = 0; i < 4; i++) begin
                if (i < nb) bus_rdata = {bus_rdata[23:0], m[a + 9'(i)]};
            end
        end
    end
    // wait counter, idle pattern and sized writes
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q <= 4'h0;
            last_q <= 32'h0000_0000;
        end else begin
            last_q <= bus_rdata;
            cnt_q <= (bus_ack || !bus_req) ? 4'h0 : cnt_q + 4'h1;
            if (bus_ack && bus_we) begin
                for (int i = 0; i < 4; i++) begin
                    if (i < nb) m[a + 9'(i)] <= bus_wdata[8 * (nb - 1 - i) +: 8];
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: testbench/tb_system_control_insn_decode.sv
/*
 * self-checking bench: small programs run from the memory model, results read back.
 * assumes the core resets to pc 0 and sleeps at the end of each program.
 */
`default_nettype none
module tb_system_control_insn_decode;
    timeunit 1ns;
    timeprecision 1ns;
    import scd_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic wake = 1'b0;
    logic [3:0] wait_n = 4'h0;
    logic bus_req_q, bus_fetch_q, bus_we_q, bus_ack, power_down_q, trap_q, stall_ld_q, contend_q;
    scd_size_t bus_size_q;
    logic [31:0] bus_addr_q, bus_wdata_q, bus_rdata, status_q, pc_q;
    int mismatches = 0, n_compared = 0, n_stall = 0, n_trap = 0, n_contend = 0, cyc = 0;
    // clock
    always #50 clk_sys = ~clk_sys;
    scd_core uut (.clk_sys(clk_sys), .rst(rst), .bus_req_q(bus_req_q), .bus_fetch_q(bus_fetch_q),
        .bus_we_q(bus_we_q), .bus_size_q(bus_size_q), .bus_addr_q(bus_addr_q),
        .bus_wdata_q(bus_wdata_q), .bus_ack(bus_ack), .bus_rdata(bus_rdata), .wake(wake),
        .status_q(status_q), .pc_q(pc_q), .power_down_q(power_down_q), .trap_q(trap_q),
        .stall_ld_q(stall_ld_q), .contend_q(contend_q));
    scd_mem_model mem (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req_q), .bus_we(bus_we_q),
        .bus_size(bus_size_q), .bus_addr(bus_addr_q), .bus_wdata(bus_wdata_q),
        .bus_ack(bus_ack), .bus_rdata(bus_rdata), .wait_n(wait_n));
    // pulse counters, sampled mid-cycle
    always @(negedge clk_sys) begin
        cyc++;
        n_stall += (stall_ld_q === 1'b1);
        n_trap += (trap_q === 1'b1);
        n_contend += (contend_q === 1'b1);
    end
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    function automatic logic [31:0] rd32(int a);
        return {mem.m[a], mem.m[a + 1], mem.m[a + 2], mem.m[a + 3]};
    endfunction
    task automatic put32(int a, logic [31:0] v);
        for (int i = 0; i < 4; i++) mem.m[a + i] = v[31 - 8 * i -: 8];
    endtask
    // program from address 0, two bytes per code
    task automatic prog(logic [15:0] c[$]);
        foreach (c[i]) begin
            mem.m[2 * i] = c[i][15:8];
            mem.m[2 * i + 1] = c[i][7:0];
        end
    endtask
    task automatic start(logic [3:0] w);
        @(posedge clk_sys);
        rst <= 1'b1;
        wait_n <= w;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        n_stall = 0;
        n_trap = 0;
        n_contend = 0;
        cyc = 0;
    endtask
    // bounded wait for the closing sleep code
    task automatic run_to_sleep();
        int k;
        for (k = 0; k < 600 && power_down_q !== 1'b1; k++) @(negedge clk_sys);
        if (k == 600) begin
            mismatches++;
            $display("[FAIL] sleep expected 1 seen 0");
            final_report();
        end
    endtask
    task automatic sc_reset();
        @(negedge clk_sys);
        check("status reset", status_q, SR_RESET);
        check("pc reset", pc_q, 32'h0000_0000);
        check("fetch reset", {31'h0, bus_fetch_q}, 32'h1);
    endtask
    // flag set/clear, control and system register moves, sleep and wake
    task automatic sc_ctl_sys(logic [3:0] w);
        for (int i = 'hF0; i < 'hFC; i += 4) put32(i, 32'hAAAA_AAAA);
        prog('{16'h0018, 16'h0202, 16'h0008, 16'h0102, 16'h2122, 16'h411A, 16'h031A,
            16'h1131, 16'h0028, 16'h041A, 16'h1142, 16'h420E, 16'h001B});
        start(w);
        run_to_sleep();
        check("store status", rd32('hF0), 32'h0000_00F1);
        check("acc low", rd32('hF4), 32'h0000_00F0);
        check("acc clear", rd32('hF8), 32'h0000_0000);
        check("status load", status_q, 32'h0000_00F1);
        @(posedge clk_sys);
        wake <= 1'b1;
        @(posedge clk_sys);
        wake <= 1'b0;
        @(negedge clk_sys);
        check("wake", {31'h0, power_down_q}, 32'h0);
    endtask
    // sign-extended loads, byte/word stores, load-use stalls
    task automatic sc_sizes();
        for (int i = 'hF0; i < 'h108; i += 4) put32(i, 32'hAAAA_AAAA);
        put32('hF0, 32'h8001_AAAA);
        prog('{16'h0008, 16'h0102, 16'h8510, 16'h1103, 16'h8018, 16'h8410, 16'h1104,
            16'h8115, 16'h001B});
        start(4'h0);
        run_to_sleep();
        check("word load", rd32('hFC), 32'hFFFF_8001);
        check("byte load", rd32('h100), 32'hFFFF_FF80);
        check("b/w store", rd32('hF8), 32'h01AA_FF80);
        check("stalls", n_stall, 32'h2);
    endtask
    // wait states stretch the run and show contention
    task automatic sc_contend();
        int c0;
        sc_ctl_sys(4'h0);
        c0 = cyc;
        sc_ctl_sys(4'h2);
        check("slower", {31'h0, cyc > c0}, 32'h1);
        check("contend", {31'h0, n_contend > 0}, 32'h1);
    endtask
    // trap through a vector, handler sets flag, return restores status
    task automatic sc_trap();
        put32('h104, 32'hAAAA_AAAA);
        put32('h108, 32'hAAAA_AAAA);
        put32('h10C, 32'hAAAA_AAAA);
        put32('h130, 32'h0000_0100);
        prog('{16'h0008, 16'h0102, 16'h412E, 16'hC310, 16'h0502, 16'h1155, 16'h410A, 16'h070A,
            16'h5614, 16'h1166, 16'h1177, 16'h001B});
        mem.m['h100] = 8'h00;
        mem.m['h101] = 8'h18;
        mem.m['h102] = 8'h00;
        mem.m['h103] = 8'h2B;
        start(4'h1);
        run_to_sleep();
        check("trap pulse", n_trap, 32'h1);
        check("saved status", rd32('h104), 32'h0000_00F0);
        check("status after", status_q, 32'h0000_00F0);
        check("long disp load", rd32('h108), 32'h0018_002B);
        check("acc high", rd32('h10C), 32'h0000_00F0);
    endtask
    initial begin
        sc_reset();
        sc_ctl_sys(4'h0);
        sc_sizes();
        sc_contend();
        sc_trap();
        final_report();
    end
endmodule
`default_nettype wire
